// ==== core/pvb_channel.sv ====
// module: one timer channel with buffered compare value, counter and pulse output
`timescale 1ns/1ps
module pvb_channel (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic [pvb_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [pvb_pkg::DATA_W-1:0] WR_DATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic DEBUG_MODE_I,
    output logic [pvb_pkg::DATA_W-1:0] RD_DATA_O,
    output logic PWM_O
);

    ////////////////////////////////////////////////////////////////////////////
    // decode
    logic wr_sc, wr_cnt, wr_mod_hi, wr_mod_lo, wr_cc, wr_val_hi, wr_val_lo;
    assign wr_sc = WR_I && (ADDR_I == pvb_pkg::OFS_STATUS_CTRL);
    assign wr_cnt = WR_I && (ADDR_I == pvb_pkg::OFS_COUNT_HI || ADDR_I == pvb_pkg::OFS_COUNT_LO);
    assign wr_mod_hi = WR_I && (ADDR_I == pvb_pkg::OFS_MOD_HI);
    assign wr_mod_lo = WR_I && (ADDR_I == pvb_pkg::OFS_MOD_LO);
    assign wr_cc = WR_I && (ADDR_I == pvb_pkg::OFS_CHAN_CTRL);
    assign wr_val_hi = WR_I && (ADDR_I == pvb_pkg::OFS_VALUE_HI);
    assign wr_val_lo = WR_I && (ADDR_I == pvb_pkg::OFS_VALUE_LO);

    ////////////////////////////////////////////////////////////////////////////
    // debug mode input: three flops, change taken once the last two agree
    logic dbg_s1_q, dbg_s2_q, dbg_s3_q, dbg_q;
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            dbg_s1_q <= 1'b0;
            dbg_s2_q <= 1'b0;
            dbg_s3_q <= 1'b0;
            dbg_q <= 1'b0;
        end else begin
            dbg_s1_q <= DEBUG_MODE_I;
            dbg_s2_q <= dbg_s1_q;
            dbg_s3_q <= dbg_s2_q;
            if (dbg_s2_q == dbg_s3_q) begin
                dbg_q <= dbg_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    pvb_pkg::pvb_status_ctrl_t sc_q;
    pvb_pkg::pvb_chan_ctrl_t cc_q;
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sc_q <= pvb_pkg::STATUS_RESET;
            cc_q <= pvb_pkg::CHAN_RESET;
        end else begin
            if (wr_sc) begin
                sc_q <= WR_DATA_I;
            end
            if (wr_cc) begin
                cc_q <= WR_DATA_I;
            end
        end
    end

    logic running, center, edge_mode, cmp_mode, cap_mode, active_lvl;
    assign running = (sc_q.clock_source_select != pvb_pkg::CLKS_STOPPED);
    assign center = sc_q.center;
    assign edge_mode = !center && (cc_q.mode == pvb_pkg::MODE_EDGE_PWM);
    assign cmp_mode = !center && (cc_q.mode == pvb_pkg::MODE_COMPARE);
    assign cap_mode = !center && (cc_q.mode == pvb_pkg::MODE_CAPTURE);
    assign active_lvl = !cc_q.low_true;

    ////////////////////////////////////////////////////////////////////////////
    // modulo with byte pairing
    logic [pvb_pkg::CNT_W-1:0] mod_q;
    logic [pvb_pkg::DATA_W-1:0] mod_hi_q;
    logic mod_half_q;
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mod_q <= pvb_pkg::CNT_ZERO;
            mod_hi_q <= pvb_pkg::BYTE_ZERO;
            mod_half_q <= 1'b0;
        end else if (wr_sc && dbg_q) begin
            mod_half_q <= 1'b0;
        end else if (wr_mod_hi) begin
            mod_hi_q <= WR_DATA_I;
            mod_half_q <= 1'b1;
        end else if (wr_mod_lo && mod_half_q) begin
            mod_q <= {mod_hi_q, WR_DATA_I};
            mod_half_q <= 1'b0;
        end
    end

    // 0 or FFFF in the modulo means free running
    logic [pvb_pkg::CNT_W-1:0] top;
    assign top = (mod_q == pvb_pkg::CNT_ZERO) ? pvb_pkg::CNT_FULL : mod_q;

    ////////////////////////////////////////////////////////////////////////////
    // prescaler: one-cycle tick per counter step; frozen in debug mode
    logic [pvb_pkg::PS_W-1:0] ps_q, ps_mask;
    logic tick;
    assign ps_mask = pvb_pkg::PS_MASK_ALL >> (3'h7 - sc_q.prescale);
    assign tick = running && !dbg_q && ((ps_q & ps_mask) == ps_mask);
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ps_q <= pvb_pkg::PS_ZERO;
        end else if (wr_cnt) begin
            ps_q <= pvb_pkg::PS_ZERO;
        end else if (running && !dbg_q) begin
            ps_q <= tick ? pvb_pkg::PS_ZERO : ps_q + pvb_pkg::PS_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter: up-only, or up/down in center mode
    logic [pvb_pkg::CNT_W-1:0] cnt_q;
    pvb_pkg::pvb_dir_t dir_q;
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt_q <= pvb_pkg::CNT_ZERO;
            dir_q <= pvb_pkg::DIR_UP;
        end else if (wr_cnt) begin
            cnt_q <= pvb_pkg::CNT_ZERO;
            dir_q <= pvb_pkg::DIR_UP;
        end else if (tick) begin
            case (dir_q)
                pvb_pkg::DIR_UP: begin
                    if (cnt_q >= top && center) begin
                        cnt_q <= cnt_q - pvb_pkg::CNT_ONE;
                        dir_q <= pvb_pkg::DIR_DOWN;
                    end else if (cnt_q >= top) begin
                        cnt_q <= pvb_pkg::CNT_ZERO;
                    end else begin
                        cnt_q <= cnt_q + pvb_pkg::CNT_ONE;
                    end
                end
                pvb_pkg::DIR_DOWN: begin
                    if (cnt_q == pvb_pkg::CNT_ZERO) begin
                        cnt_q <= pvb_pkg::CNT_ONE;
                        dir_q <= pvb_pkg::DIR_UP;
                    end else begin
                        cnt_q <= cnt_q - pvb_pkg::CNT_ONE;
                    end
                end
                default: begin
                    dir_q <= pvb_pkg::DIR_UP;
                end
            endcase
        end
    end

    // counter about to step to its top value
    logic step_top;
    assign step_top = tick && (dir_q == pvb_pkg::DIR_UP) && (cnt_q == top - pvb_pkg::CNT_ONE);

    ////////////////////////////////////////////////////////////////////////////
    // compare value: write buffer, byte pairing, load
    logic [pvb_pkg::CNT_W-1:0] val_buf_q, cv_q;
    logic val_half_q, pend_q, pair_done, load_pwm, load_cmp, load_now;
    assign pair_done = wr_val_lo && val_half_q && !cap_mode;
    // a half-written pair holds back the pending load; a status/control write clears the half flag, so a mixed value can then load
    assign load_pwm = pend_q && !val_half_q && running && (edge_mode || center) && step_top;
    assign load_cmp = pend_q && !val_half_q && running && cmp_mode && tick;
    assign load_now = pair_done && !running;

    // input capture writes are dropped; software must not issue them
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            val_buf_q <= pvb_pkg::CNT_ZERO;
            val_half_q <= 1'b0;
        end else if (wr_sc) begin
            val_half_q <= 1'b0;
        end else if (wr_val_hi && !cap_mode) begin
            val_buf_q[15:8] <= WR_DATA_I;
            val_half_q <= 1'b1;
        end else if (wr_val_lo && !cap_mode) begin
            val_buf_q[7:0] <= WR_DATA_I;
            val_half_q <= 1'b0;
        end
    end

    // a pair completed in the load cycle stays pending: set wins
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pend_q <= 1'b0;
        end else if (pair_done && running) begin
            pend_q <= 1'b1;
        end else if (load_pwm || load_cmp || !running) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cv_q <= pvb_pkg::CNT_ZERO;
        end else if (load_now) begin
            cv_q <= {val_buf_q[15:8], WR_DATA_I};
        end else if (load_pwm || load_cmp) begin
            cv_q <= val_buf_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // duty in use: in center mode with a running clock source, zero transitions wait for the period start at the top count; zero is mid-period
    logic [pvb_pkg::CNT_W-1:0] duty_q;
    logic zero_edge;
    assign zero_edge = (cv_q == pvb_pkg::CNT_ZERO) != (duty_q == pvb_pkg::CNT_ZERO);
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            duty_q <= pvb_pkg::CNT_ZERO;
        end else if (!running || !center || !zero_edge || cnt_q == top) begin
            duty_q <= cv_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulse output
    logic cen_active;
    // duty at or above top holds the output on the whole period
    assign cen_active = (duty_q >= top) || (cnt_q < duty_q);
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PWM_O <= 1'b0;
        end else if (center) begin
            PWM_O <= cen_active ? active_lvl : !active_lvl;
        end else if (edge_mode) begin
            PWM_O <= (cnt_q < duty_q) ? active_lvl : !active_lvl;
        end else if (cmp_mode && tick && cnt_q == cv_q) begin
            PWM_O <= !PWM_O;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RD_DATA_O <= pvb_pkg::BYTE_ZERO;
        end else if (!RD_I) begin
            RD_DATA_O <= pvb_pkg::BYTE_ZERO;
        end else begin
            case (ADDR_I)
                pvb_pkg::OFS_STATUS_CTRL: RD_DATA_O <= sc_q;
                pvb_pkg::OFS_COUNT_HI: RD_DATA_O <= cnt_q[15:8];
                pvb_pkg::OFS_COUNT_LO: RD_DATA_O <= cnt_q[7:0];
                pvb_pkg::OFS_MOD_HI: RD_DATA_O <= mod_q[15:8];
                pvb_pkg::OFS_MOD_LO: RD_DATA_O <= mod_q[7:0];
                pvb_pkg::OFS_CHAN_CTRL: RD_DATA_O <= cc_q;
                pvb_pkg::OFS_VALUE_HI: RD_DATA_O <= cv_q[15:8];
                pvb_pkg::OFS_VALUE_LO: RD_DATA_O <= cv_q[7:0];
                default: RD_DATA_O <= pvb_pkg::BYTE_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    property p_edge_load;
        (edge_mode && running && pend_q && !val_half_q && step_top && !wr_sc) |=> (cv_q == $past(val_buf_q)) && !pend_q;
    endproperty
    a_edge_load: assert property (p_edge_load) else $error("edge pwm value not loaded at top step");

    property p_center_load;
        (center && running && pend_q && !step_top && !load_now) |=> (cv_q == $past(cv_q));
    endproperty
    a_center_load: assert property (p_center_load) else $error("center pwm value loaded off top step");

    property p_free_top;
        (load_pwm && mod_q == pvb_pkg::CNT_ZERO) |-> (cnt_q == 16'hFFFE);
    endproperty
    a_free_top: assert property (p_free_top) else $error("free running load not at FFFE");

    property p_full_duty;
        (center && duty_q == top && !wr_sc && !wr_cc) |=> (PWM_O == active_lvl);
    endproperty
    a_full_duty: assert property (p_full_duty) else $error("full duty output went inactive");

    property p_near_full;
        (center && duty_q == top - pvb_pkg::CNT_ONE && cnt_q < duty_q && !wr_sc && !wr_cc) |=> PWM_O == active_lvl;
    endproperty
    a_near_full: assert property (p_near_full) else $error("near full duty output inactive");

    property p_zero_rise;
        (center && running && duty_q == pvb_pkg::CNT_ZERO && cnt_q != top) |=> duty_q == pvb_pkg::CNT_ZERO;
    endproperty
    a_zero_rise: assert property (p_zero_rise) else $error("zero to nonzero applied mid period");

    property p_zero_fall;
        (center && running && duty_q != pvb_pkg::CNT_ZERO && cnt_q != top) |=> duty_q != pvb_pkg::CNT_ZERO;
    endproperty
    a_zero_fall: assert property (p_zero_fall) else $error("nonzero to zero applied mid period");

    property p_dbg_mod;
        (wr_sc && dbg_q) ##1 (WR_I && ADDR_I == pvb_pkg::OFS_MOD_LO) |=> $stable(mod_q);
    endproperty
    a_dbg_mod: assert property (p_dbg_mod) else $error("half modulo survived debug status write");

    property p_cmp_load;
        (cmp_mode && running && pend_q && !val_half_q && tick && !wr_sc && !wr_cc) |=> cv_q == $past(val_buf_q);
    endproperty
    a_cmp_load: assert property (p_cmp_load) else $error("compare value not loaded at counter step");

    property p_cnt_clear;
        wr_cnt |=> (cnt_q == pvb_pkg::CNT_ZERO) && (ps_q == pvb_pkg::PS_ZERO);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear counter");

    property p_direct_load;
        (!running && wr_val_lo && val_half_q && !cap_mode) |=> cv_q == {$past(val_buf_q[15:8]), $past(WR_DATA_I)};
    endproperty
    a_direct_load: assert property (p_direct_load) else $error("stopped timer value not loaded directly");

    c_edge_load: cover property (edge_mode && load_pwm);
    c_center_load: cover property (center && load_pwm);
    c_zero_wait: cover property (center && running && zero_edge && cnt_q == top);
    c_dbg_clear: cover property (wr_sc && dbg_q && mod_half_q);

endmodule // pvb_channel

// ==== include/pvb_pkg.sv ====
// package: register map, field layout and constants for the channel value buffer
// Functional notes
// - In edge-aligned pulse mode with a running clock source, a written compare value loads only after both bytes and as the counter steps from modulo minus one to modulo.
// - In center-aligned pulse mode with a running clock source, a written compare value loads only after both bytes and as the counter steps from modulo minus one to modulo.
// - With a free-running counter, that load happens as the counter steps from FFFE to FFFF.
// - In center-aligned pulse mode a compare value equal to the modulo keeps the output active all period.
// - In center-aligned pulse mode a compare value of modulo minus one gives an output active nearly all period.
// - In center-aligned pulse mode with a running clock source, a change from zero to nonzero takes effect only when a new period starts.
// - In center-aligned pulse mode with a running clock source, a change from nonzero to zero lets the current period finish with the old duty.
// - In background debug mode a write to the status/control register discards a half-written modulo value.
// - In output compare mode with a running clock source, the compare value loads at the next counter step after the second byte.
// - A write to either counter byte clears the counter and the prescaler.
package pvb_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PS_W = 7;
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HI = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LO = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_MOD_HI = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_MOD_LO = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_CHAN_CTRL = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_VALUE_HI = 3'h6;
    localparam logic [ADDR_W-1:0] OFS_VALUE_LO = 3'h7;
    // status/control: [5] center mode, [4:3] clock source, [2:0] prescale
    typedef struct packed {
        logic [1:0] spare;
        logic center;
        logic [1:0] clock_source_select;
        logic [2:0] prescale;
    } pvb_status_ctrl_t;
    typedef enum logic [1:0] {
        MODE_CAPTURE = 2'h0,
        MODE_COMPARE = 2'h1,
        MODE_EDGE_PWM = 2'h3
    } pvb_chan_mode_t;
    // channel control: [2] low-true output, [1:0] mode
    typedef struct packed {
        logic [4:0] spare;
        logic low_true;
        logic [1:0] mode;
    } pvb_chan_ctrl_t;
    typedef enum logic {
        DIR_UP = 1'b0,
        DIR_DOWN = 1'b1
    } pvb_dir_t;
    localparam logic [1:0] CLKS_STOPPED = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_FULL = 16'hFFFF;
    localparam logic [PS_W-1:0] PS_ZERO = 7'h00;
    localparam logic [PS_W-1:0] PS_ONE = 7'h01;
    localparam logic [PS_W-1:0] PS_MASK_ALL = 7'h7F;
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CHAN_RESET = 8'h00;
endpackage

// ==== testbench/pvb_channel_tb.sv ====
// testbench: self-checking bench for the buffered channel compare value
`timescale 1ns/1ps
module pvb_channel_tb;
    typedef struct packed {
        logic [1:0] op;
        logic [2:0] a;
        logic [7:0] d;
    } pvb_row_t;
    logic ref_clk;
    logic rst_n;
    logic [pvb_pkg::ADDR_W-1:0] addr;
    logic [pvb_pkg::DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic dbg;
    logic [pvb_pkg::DATA_W-1:0] rdata;
    logic pwm;
    logic [7:0] v;
    logic [7:0] h;
    logic ok;
    int hits;
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    // op 0 write, 1 read back, 2 output level; clock source stays stopped throughout
    pvb_row_t rows [24] = '{
        {2'h0, 3'h5, 8'h03}, {2'h1, 3'h5, 8'h03}, {2'h0, 3'h3, 8'h12}, {2'h0, 3'h4, 8'h34},
        {2'h1, 3'h3, 8'h12}, {2'h1, 3'h4, 8'h34}, {2'h0, 3'h6, 8'hAB}, {2'h0, 3'h7, 8'hCD},
        {2'h1, 3'h6, 8'hAB}, {2'h1, 3'h7, 8'hCD}, {2'h0, 3'h6, 8'h00}, {2'h0, 3'h7, 8'h04},
        {2'h2, 3'h0, 8'h01}, {2'h0, 3'h5, 8'h07}, {2'h1, 3'h5, 8'h07}, {2'h2, 3'h0, 8'h00},
        {2'h0, 3'h5, 8'h00}, {2'h0, 3'h6, 8'h11}, {2'h0, 3'h7, 8'h22}, {2'h1, 3'h6, 8'h00},
        {2'h1, 3'h7, 8'h04}, {2'h1, 3'h1, 8'h00}, {2'h0, 3'h0, 8'h05}, {2'h1, 3'h0, 8'h05}};

    pvb_channel i_dut (
        .REF_CLK_I(ref_clk),
        .RST_N_I(rst_n),
        .ADDR_I(addr),
        .WR_DATA_I(wdata),
        .WR_I(wr),
        .RD_I(rd),
        .DEBUG_MODE_I(dbg),
        .RD_DATA_O(rdata),
        .PWM_O(pwm)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // the free-running load alone needs about 65.5k cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            num_errors = num_errors + 1;
            $display("[ERR] t=%0t timeout cycles=%h limit=%h", $time, cycles, 90000);
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // every call assigns each bus signal once, so back-to-back cycles never race
    task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 3'h0, 8'h00);
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        bus(1'b0, 1'b1, a, 8'h00);
        d = rdata;
    endtask

    task automatic wv(input logic [2:0] a, input logic [15:0] w);
        wr_reg(a, w[15:8]);
        wr_reg(a + 3'h1, w[7:0]);
    endtask

    // poll count hi, count lo, value lo; the count read just before the new value must sit at top-1 or top, or its low byte at 00
    task automatic wait_load(input logic [15:0] top, input logic [7:0] new_lo);
        logic [7:0] c;
        v = 8'h00;
        for (int n = 0; n < 30000 && v !== new_lo; n++) begin
            rd_reg(3'h1, h);
            rd_reg(3'h2, c);
            rd_reg(3'h7, v);
        end
        idle(1);
        ok = (v === new_lo) && (h === top[15:8]);
        ok = ok && ((c === top[7:0]) || (c === top[7:0] - 8'h01) || (c === 8'h00));
    endtask

    // returns right after the counter was seen at val, moving in the given direction
    task automatic sync_cnt(input logic [7:0] val, input logic down);
        logic [7:0] p;
        p = 8'h00;
        v = 8'h00;
        for (int n = 0; n < 200 && !(v === val && p === (down ? val + 8'h01 : val - 8'h01)); n++) begin
            p = v;
            rd_reg(3'h2, v);
        end
        idle(1);
    endtask

    task automatic count_pwm(input int n);
        hits = 0;
        repeat (n) begin
            idle(1);
            hits = hits + int'(pwm === 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        dbg = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 24; i++) begin
            case (rows[i].op)
                2'h0: wr_reg(rows[i].a, rows[i].d);
                2'h1: begin
                    rd_reg(rows[i].a, v);
                    chk({8'h00, v}, {8'h00, rows[i].d});
                end
                default: begin
                    idle(2);
                    chk({15'h0000, pwm}, {8'h00, rows[i].d});
                end
            endcase
        end
        $display("register rows done");
        // edge mode: a lone high byte must not load across a whole period
        wr_reg(3'h5, 8'h03);
        wv(3'h3, 16'h0010);
        wv(3'h6, 16'h0004);
        wr_reg(3'h0, 8'h08);
        wr_reg(3'h6, 8'h00);
        idle(40);
        rd_reg(3'h7, v);
        chk({8'h00, v}, 16'h0004);
        wr_reg(3'h7, 8'h09);
        wait_load(16'h0010, 8'h09);
        chk({15'h0000, ok}, 16'h0001);
        count_pwm(34);
        chk(16'(hits), 16'h0012);
        wr_reg(3'h0, 8'h28);
        wv(3'h6, 16'h0005);
        wait_load(16'h0010, 8'h05);
        chk({15'h0000, ok}, 16'h0001);
        $display("buffered load done");
        wr_reg(3'h0, 8'h20);
        wv(3'h6, 16'h0010);
        wr_reg(3'h0, 8'h28);
        count_pwm(64);
        chk(16'(hits), 16'h0040);
        wr_reg(3'h0, 8'h20);
        wv(3'h6, 16'h000F);
        wr_reg(3'h0, 8'h28);
        count_pwm(64);
        chk({15'h0000, hits > 48 && hits < 64}, 16'h0001);
        $display("center duty done");
        // zero transitions written before mid-period: this period keeps the old duty, the next takes the new
        wr_reg(3'h0, 8'h20);
        wv(3'h6, 16'h0000);
        wr_reg(3'h0, 8'h28);
        for (int k = 0; k < 2; k++) begin
            sync_cnt(8'h0C, 1'b1);
            wv(3'h6, (k == 0) ? 16'h0004 : 16'h0000);
            count_pwm(25);
            chk(16'(hits), (k == 0) ? 16'h0000 : 16'h0007);
            count_pwm(32);
            chk(16'(hits), (k == 0) ? 16'h0007 : 16'h0000);
        end
        $display("zero transitions done");
        // compare mode with divide-by-128: the counter write also restarts the prescaler
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h5, 8'h01);
        wv(3'h6, 16'h0030);
        wr_reg(3'h0, 8'h0F);
        wr_reg(3'h1, 8'hA5);
        wv(3'h6, 16'h0031);
        rd_reg(3'h7, v);
        chk({8'h00, v}, 16'h0030);
        rd_reg(3'h1, h);
        rd_reg(3'h2, v);
        chk({h, v}, 16'h0000);
        // one cycle before the first counter step, 128 cycles after the counter write: an uncleared prescaler would already have loaded
        idle(122);
        rd_reg(3'h7, v);
        chk({8'h00, v}, 16'h0030);
        idle(6);
        rd_reg(3'h7, v);
        chk({8'h00, v}, 16'h0031);
        $display("compare load done");
        wr_reg(3'h0, 8'h00);
        wr_reg(3'h5, 8'h03);
        wv(3'h3, 16'h0000);
        wv(3'h6, 16'h0002);
        wr_reg(3'h0, 8'h08);
        wr_reg(3'h2, 8'h00);
        wv(3'h6, 16'h0003);
        wait_load(16'hFFFF, 8'h03);
        chk({15'h0000, ok}, 16'h0001);
        $display("free running done");
        // status write splits a modulo pair only while debug mode is active
        wr_reg(3'h0, 8'h00);
        for (int k = 0; k < 2; k++) begin
            dbg <= (k == 0);
            idle(6);
            wr_reg(3'h3, 8'h55);
            wr_reg(3'h0, 8'h00);
            wr_reg(3'h4, 8'h20);
            rd_reg(3'h3, v);
            chk({8'h00, v}, (k == 0) ? 16'h0000 : 16'h0055);
        end
        $display("debug coherency done");
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd_reg(3'(a), v);
            chk({7'h00, pwm, v}, 16'h0000);
        end
        $display("second reset done");
        stop_test();
    end
endmodule // pvb_channel_tb
